// ===== ndef_host.sv
`timescale 1ns/10ps
`include "ndef_host_regs.svh"
// Overview of operation
// - Attribute block written to block 0
// - Message file in blocks 1 to 23
// - Program system code 0x12FC
// - Offset 0 holds mapping version
// - Offset 1 holds read limit 0x0F
// - Offset 2 holds write limit 0x0B
// - Block count capped 0x17 or 0x1A
// - Encrypted use caps count at 0x18
// - Offsets 5 to 8 written zero
// - Flag 0x0F before, 0x00 after writing
// - Offset 0x0A: 0 read-only, 1 writable
// - Offsets 0x0B-0x0D hold message length
// - Checksum sums offsets 0 to 0x0D
// - Empty message D00000 at 0x0010
module ndef_host (
    input  wire logic                   aclk,         // System clock
    input  wire logic                   aresetn,      // Sync reset, low
    input  wire logic [3:0]             awaddr,       // Write address
    input  wire logic                   awvalid,      // Write address valid
    output logic                        awready,      // Write address ready
    input  wire logic [31:0]            wdata,        // Write data
    input  wire logic [3:0]             wstrb,        // Byte enables
    input  wire logic                   wvalid,       // Write data valid
    output logic                        wready,       // Write data ready
    output logic [1:0]                  bresp,        // Write response
    output logic                        bvalid,       // Response valid
    input  wire logic                   bready,       // Response ready
    input  wire logic [3:0]             araddr,       // Read address
    input  wire logic                   arvalid,      // Read address valid
    output logic                        arready,      // Read address ready
    output logic [31:0]                 rdata,        // Read data
    output logic [1:0]                  rresp,        // Read response
    output logic                        rvalid,       // Read data valid
    input  wire logic                   rready,       // Read data ready
    output ndef_host_pkg::tag_req_t     tag_req,      // Order to the tag
    output logic                        tag_valid,    // Order valid
    input  wire logic                   tag_ready     // Tag took order
);
    logic                       awready_r;     // Address slot free
    logic                       wready_r;      // Data slot free
    logic                       aw_got_r;      // Address held
    logic                       w_got_r;       // Data held
    logic [3:0]                 waddr_r;       // Held address
    logic [31:0]                wdata_r;       // Held data
    logic [3:0]                 wstrb_r;       // Held strobes
    logic                       bvalid_r;      // Response pending
    logic [1:0]                 bresp_r;       // Response code
    logic                       arready_r;     // Read slot free
    logic                       rvalid_r;      // Read data pending
    logic [31:0]                rdata_r;       // Read data
    logic [1:0]                 rresp_r;       // Read code
    logic [31:0]                cfg_r;         // Configuration
    logic [23:0]                len_r;         // Message length
    logic                       open_r;        // Message write open
    ndef_host_pkg::seq_state_t  state_r;       // Sequencer state
    ndef_host_pkg::tag_req_t    req_r;         // Order to tag
    logic                       tvalid_r;      // Order valid
    logic                       from_cmd_r;    // Sequence started by begin or commit
    logic [23:0]                ln_r;          // Length for next block 0
    logic                       do_wr;         // Register write now
    logic [31:0]                merged;        // Strobed write value
    logic [15:0]                maxb_eff;      // Capped block count
    logic                       idle;          // Sequencer free
    // Sum of the fourteen leading bytes of block 0
    function automatic logic [15:0] aib_sum(input logic [127:0] b);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 14; i++) begin
            s = s + {8'h00, b[127-8*i -: 8]};
        end
        return s;
    endfunction
    // Block 0 image, offset 0 in the top byte
    function automatic logic [127:0] aib_image(input logic [7:0] ver,
        input logic [15:0] maxb, input logic [7:0] wf, input logic rw,
        input logic [23:0] ln);
        logic [127:0] b;
        b = {ver, `NDEF_NBR, `NDEF_NBW, maxb, 32'h0000_0000, wf,
             7'h00, rw, ln, 16'h0000};
        b[15:0] = aib_sum(b);
        return b;
    endfunction
    // Cap the block count; the encryption cap wins over type-3-only
    always_comb begin
        logic [15:0] lim;
        lim = cfg_r[`CFG_T3_BIT] ? `MAXB_T3 : `MAXB_SHARED;
        lim = cfg_r[`CFG_ENC_BIT] ? `MAXB_ENC : lim;
        maxb_eff = (cfg_r[`CFG_MAXB_LSB +: 16] > lim) ? lim : cfg_r[`CFG_MAXB_LSB +: 16];
    end
    assign do_wr = aw_got_r && w_got_r && !bvalid_r;
    assign idle  = (state_r == ndef_host_pkg::st_idle);
    // Byte enables applied over the old value
    always_comb begin
        logic [31:0] old;
        old = (waddr_r == `REG_LEN) ? {8'h00, len_r} : cfg_r;
        for (int i = 0; i < 4; i++) begin
            merged[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8] : old[8*i +: 8];
        end
    end
    // Write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            waddr_r   <= 4'h0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (awvalid && awready_r) begin
                aw_got_r  <= 1'b1;
                awready_r <= 1'b0;
                waddr_r   <= awaddr;
            end else if (do_wr) begin
                aw_got_r  <= 1'b0;
            end
            if (wvalid && wready_r) begin
                w_got_r  <= 1'b1;
                wready_r <= 1'b0;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end else if (do_wr) begin
                w_got_r  <= 1'b0;
            end
            // Slots reopen only once the response is taken
            if (bvalid_r && bready) begin
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end
    // Write response, one per write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (waddr_r == `REG_STAT) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid_r <= 1'b0;
        end
    end
    // Configuration and length; held steady while a sequence runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= `CFG_RST;
            len_r <= 24'h000000;
        end else if (do_wr && idle) begin
            if (waddr_r == `REG_CFG) begin
                cfg_r <= {5'h00, merged[26:0]};
            end
            if (waddr_r == `REG_LEN) begin
                len_r <= merged[23:0];
            end
        end
    end
    // Read channel; unmapped reads give zero with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `RESP_OKAY;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= `RESP_OKAY;
            case (araddr)
                `REG_CTRL: rdata_r <= 32'h0000_0000;
                `REG_CFG:  rdata_r <= cfg_r;
                `REG_LEN:  rdata_r <= {8'h00, len_r};
                `REG_STAT: rdata_r <= {maxb_eff, 14'h0000, open_r, !idle};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end
    // Sequencer: orders are ignored while a sequence is running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r  <= ndef_host_pkg::st_idle;
            tvalid_r <= 1'b0;
            req_r    <= '0;
            from_cmd_r <= 1'b0;
            ln_r     <= `EMPTY_LEN;
            open_r   <= 1'b0;
        end else begin
            case (state_r)
                ndef_host_pkg::st_idle: begin
                    if (do_wr && waddr_r == `REG_CTRL && wstrb_r[0]) begin
                        if (wdata_r[`CTRL_FMT]) begin
                            // Format: system code, block 0, empty file
                            state_r     <= ndef_host_pkg::st_sc;
                            tvalid_r    <= 1'b1;
                            req_r.kind  <= ndef_host_pkg::req_syscode;
                            req_r.block <= `NDEF_AIB_BLOCK;
                            req_r.data  <= {112'h0, `NDEF_SYS_CODE};
                            from_cmd_r  <= 1'b0;
                            ln_r        <= `EMPTY_LEN;
                            open_r      <= 1'b0;
                        end else if (wdata_r[`CTRL_BEGIN]) begin
                            state_r     <= ndef_host_pkg::st_aib;
                            tvalid_r    <= 1'b1;
                            req_r.kind  <= ndef_host_pkg::req_block;
                            req_r.block <= `NDEF_AIB_BLOCK;
                            req_r.data  <= aib_image(cfg_r[`CFG_VER_LSB +: 8],
                                maxb_eff, `WF_BUSY, cfg_r[`CFG_RW_BIT], ln_r);
                            open_r      <= 1'b1;
                            from_cmd_r  <= 1'b1;
                        end else if (wdata_r[`CTRL_COMMIT]) begin
                            // Message blocks are written by software between
                            state_r     <= ndef_host_pkg::st_aib;
                            tvalid_r    <= 1'b1;
                            req_r.kind  <= ndef_host_pkg::req_block;
                            req_r.block <= `NDEF_AIB_BLOCK;
                            ln_r        <= len_r;
                            req_r.data  <= aib_image(cfg_r[`CFG_VER_LSB +: 8],
                                maxb_eff, `WF_DONE, cfg_r[`CFG_RW_BIT], len_r);
                            open_r      <= 1'b0;
                            from_cmd_r  <= 1'b1;
                        end
                    end
                end
                ndef_host_pkg::st_sc: begin
                    if (tag_ready) begin
                        state_r     <= ndef_host_pkg::st_aib;
                        req_r.kind  <= ndef_host_pkg::req_block;
                        req_r.block <= `NDEF_AIB_BLOCK;
                        req_r.data  <= aib_image(cfg_r[`CFG_VER_LSB +: 8],
                            maxb_eff, `WF_DONE, cfg_r[`CFG_RW_BIT], ln_r);
                    end
                end
                ndef_host_pkg::st_aib: begin
                    if (tag_ready) begin
                        // Only the format sequence goes on to the file
                        if (!from_cmd_r) begin
                            state_r     <= ndef_host_pkg::st_file;
                            req_r.block <= `NDEF_FILE_BLOCK;
                            req_r.data  <= {`EMPTY_MSG, 104'h0};
                        end else begin
                            state_r  <= ndef_host_pkg::st_idle;
                            tvalid_r <= 1'b0;
                        end
                    end
                end
                ndef_host_pkg::st_file: begin
                    if (tag_ready) begin
                        state_r  <= ndef_host_pkg::st_idle;
                        tvalid_r <= 1'b0;
                    end
                end
                default: begin
                    state_r  <= ndef_host_pkg::st_idle;
                    tvalid_r <= 1'b0;
                end
            endcase
        end
    end
    assign awready   = awready_r;
    assign wready    = wready_r;
    assign bvalid    = bvalid_r;
    assign bresp     = bresp_r;
    assign arready   = arready_r;
    assign rvalid    = rvalid_r;
    assign rdata     = rdata_r;
    assign rresp     = rresp_r;
    assign tag_req   = req_r;
    assign tag_valid = tvalid_r;
    // Block 0 orders always target block 0
    property p_aib_block;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_aib) |-> req_r.block == `NDEF_AIB_BLOCK;
    endproperty
    a_aib_block: assert property (p_aib_block) else $error("block 0 misplaced");
    // File order lands inside the file area
    property p_file_block;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_file) |->
            req_r.block >= `NDEF_FILE_BLOCK && req_r.block <= `NDEF_LAST_BLOCK;
    endproperty
    a_file_block: assert property (p_file_block) else $error("file block out of range");
    // System code order carries the fixed code
    property p_syscode;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_sc) |->
            req_r.kind == ndef_host_pkg::req_syscode && req_r.data[15:0] == `NDEF_SYS_CODE;
    endproperty
    a_syscode: assert property (p_syscode) else $error("wrong system code");
    // Read and write limits in block 0
    property p_limits;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_aib) |->
            req_r.data[119:112] == `NDEF_NBR && req_r.data[111:104] == `NDEF_NBW;
    endproperty
    a_limits: assert property (p_limits) else $error("bad block limits");
    // Block count never above the largest mode cap
    property p_maxb;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_aib) |-> req_r.data[103:88] <= `MAXB_T3;
    endproperty
    a_maxb: assert property (p_maxb) else $error("block count too large");
    // Unused bytes stay zero
    property p_zero;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_aib) |-> req_r.data[87:56] == 32'h0000_0000;
    endproperty
    a_zero: assert property (p_zero) else $error("unused bytes not zero");
    // Checksum matches the leading bytes
    property p_cks;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && state_r == ndef_host_pkg::st_aib) |-> req_r.data[15:0] == aib_sum(req_r.data);
    endproperty
    a_cks: assert property (p_cks) else $error("checksum mismatch");
    // An order waiting on the tag stays unchanged
    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        (tvalid_r && !tag_ready) |=> tvalid_r && $stable(req_r);
    endproperty
    a_hold: assert property (p_hold) else $error("order changed before taken");
    // Begin raises the busy flag in block 0 within one cycle
    property p_begin;
        @(posedge aclk) disable iff (!aresetn)
        (idle && do_wr && waddr_r == `REG_CTRL && wstrb_r[0] && !wdata_r[`CTRL_FMT]
            && wdata_r[`CTRL_BEGIN]) |=> tvalid_r && req_r.data[55:48] == `WF_BUSY;
    endproperty
    a_begin: assert property (p_begin) else $error("begin did not mark busy");
endmodule // ndef_host

// ===== ndef_host_bench.sv
`timescale 1ns/10ps
`include "ndef_host_regs.svh"
module ndef_host_bench;
    logic                    aclk, aresetn;              // Clock and reset
    logic [3:0]              awaddr, araddr;             // Addresses
    logic                    awvalid, awready, wvalid, wready; // Write handshakes
    logic [31:0]             wdata, rdata;               // Data
    logic [3:0]              wstrb;                      // Byte enables
    logic [1:0]              bresp, rresp;               // Responses
    logic                    bvalid, bready, arvalid, arready, rvalid, rready;
    ndef_host_pkg::tag_req_t tag_req;                    // Order to tag
    logic                    tag_valid, tag_ready;       // Tag handshake
    logic [3:0]              delay;                      // Tag wait states
    int                      fail_count, n_tests;        // Tallies

    ndef_host i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .tag_req(tag_req), .tag_valid(tag_valid),
        .tag_ready(tag_ready));
    ndef_tag_model i_tag (.aclk(aclk), .aresetn(aresetn), .tag_req(tag_req),
        .tag_valid(tag_valid), .delay(delay), .tag_ready(tag_ready));

    // Clock, 10 ns period
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_block(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        fail_count++;
        finish_test();
    endtask
    // Write: address and data offered together, each dropped on its own take
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok, w_ok;
        int k;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin awvalid <= 1'b0; aw_ok = 1; end
            if (!w_ok && wready) begin wvalid <= 1'b0; w_ok = 1; end
            if (bvalid) begin r = bresp; bready <= 1'b0; break; end
        end
        if (k == 200) hang();
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_ok;
        int k;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (!ar_ok && arready) begin arvalid <= 1'b0; ar_ok = 1; end
            if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
        end
        if (k == 200) hang();
    endtask
    // Poll the busy bit, bounded
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 300; k++) begin
            axi_rd(`REG_STAT, d, r);
            if (d[0] === 1'b0) return;
        end
        hang();
    endtask
    // Expected attribute block image, high byte first, checksum over 14 bytes
    function automatic logic [127:0] attribute_info_block(input logic [7:0] ver, input logic [15:0] maxb,
                                         input logic [7:0] wf, input logic [7:0] rw,
                                         input logic [23:0] ln);
        logic [111:0] b;
        logic [15:0]  s;
        b = {ver, 8'h0F, 8'h0B, maxb, 32'h0000_0000, wf, rw, ln};
        s = 16'h0000;
        for (int i = 0; i < 14; i++) s = s + {8'h00, b[111-8*i -: 8]};
        return {b, s};
    endfunction
    // Reset values, read-only status and a misaligned offset
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(`REG_CFG, d, r);
        chk_word(d, `CFG_RST);
        axi_rd(`REG_LEN, d, r);
        chk_word(d, 32'h0000_0000);
        axi_wr(`REG_STAT, 32'hFFFF_FFFF, r);
        chk_word({30'h0000_0000, r}, {30'h0000_0000, `RESP_SLVERR});
        axi_rd(4'h2, d, r);
        chk_word({r, d[29:0]}, {`RESP_SLVERR, 30'h0000_0000});
    endtask
    // Format: system code, then block 0, then the empty message in block 1
    task automatic t_format(input logic [3:0] dl, input logic [31:0] cfg, input logic [15:0] cap);
        logic [1:0] r;
        delay <= dl;
        i_tag.ord_q.delete();
        axi_wr(`REG_CTRL, 32'h0000_0001, r);
        wait_idle();
        chk_word(i_tag.ord_q.size(), 32'h0000_0003);
        chk_word({16'h0000, i_tag.ord_q[0], i_tag.ord_q[1][4:0], i_tag.ord_q[2][4:0]},
                 {16'h0000, 6'h20, 5'h00, 5'h01});
        chk_word({16'h0000, i_tag.sys_code}, {16'h0000, `NDEF_SYS_CODE});
        chk_block(i_tag.mem[0], attribute_info_block(cfg[7:0], cap, `WF_DONE, {7'h00, cfg[24]}, 24'h000003));
        chk_word({8'h00, i_tag.mem[1][127:104]}, {8'h00, `EMPTY_MSG});
        chk_word(i_tag.bad_blk, 32'h0000_0000);
    endtask
    // Open and close a message write; begin keeps the stored length,
    // and a read-only block 0 makes the tag drop the commit
    task automatic t_session(input logic [31:0] cfg, input logic [15:0] cap,
                             input logic [23:0] ln, input logic [23:0] old_ln);
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(`REG_CFG, cfg, r);
        axi_rd(`REG_STAT, d, r);
        chk_word({16'h0000, d[31:16]}, {16'h0000, cap});
        axi_wr(`REG_LEN, {8'h00, ln}, r);
        axi_wr(`REG_CTRL, 32'h0000_0002, r);
        wait_idle();
        axi_rd(`REG_STAT, d, r);
        chk_word({31'h0000_0000, d[1]}, 32'h0000_0001);
        chk_block(i_tag.mem[0], attribute_info_block(cfg[7:0], cap, `WF_BUSY, {7'h00, cfg[24]}, old_ln));
        axi_wr(`REG_CTRL, 32'h0000_0004, r);
        wait_idle();
        chk_block(i_tag.mem[0], cfg[24] ? attribute_info_block(cfg[7:0], cap, `WF_DONE, 8'h01, ln)
                  : attribute_info_block(cfg[7:0], cap, `WF_BUSY, 8'h00, old_ln));
    endtask
    // Settings written while the sequencer is busy are dropped
    task automatic t_refuse();
        logic [31:0] d;
        logic [1:0]  r;
        delay <= 4'h8;
        axi_wr(`REG_CTRL, 32'h0000_0001, r);
        axi_wr(`REG_CFG, 32'h0000_0011, r);
        chk_word({30'h0000_0000, r}, {30'h0000_0000, `RESP_OKAY});
        wait_idle();
        axi_rd(`REG_CFG, d, r);
        chk_word(d, 32'h0100_1F10);
    endtask

    initial begin
        aresetn = 1'b0; awaddr = 4'h0; awvalid = 1'b0; wdata = 32'h0000_0000;
        wstrb = 4'hF; wvalid = 1'b0; bready = 1'b0; araddr = 4'h0; arvalid = 1'b0;
        rready = 1'b0; delay = 4'h0; fail_count = 0; n_tests = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_format(4'h0, `CFG_RST, `MAXB_SHARED);
        t_session(32'h0700_3010, `MAXB_ENC, 24'h000010, 24'h000003);
        t_session(32'h0100_0C10, 16'h000C, 24'hFEDCBA, 24'h000010);
        t_session(32'h0100_1F10, `MAXB_SHARED, 24'h000003, 24'hFEDCBA);
        t_refuse();
        t_format(4'h3, 32'h0100_1F10, `MAXB_SHARED);
        // Read-only block 0 last: the tag refuses block 0 for good after it
        t_session(32'h0200_2010, `MAXB_T3, 24'h123456, 24'h000003);
        finish_test();
    end
    // Whole-run guard
    initial begin
        repeat (50000) @(posedge aclk);
        hang();
    end
endmodule // ndef_host_bench

// ===== ndef_host_pkg.sv
package ndef_host_pkg;
    // Kind of write sent to the tag
    typedef enum logic [0:0] {
        req_block,
        req_syscode
    } tag_kind_t;
    // One write order to the tag
    typedef struct packed {
        tag_kind_t      kind;   // Block or system code
        logic [4:0]     block;  // Block number
        logic [127:0]   data;   // Block image, offset 0 in top byte
    } tag_req_t;
    // Sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_sc,
        st_aib,
        st_file
    } seq_state_t;
endpackage

// ===== ndef_host_regs.svh
`ifndef NDEF_HOST_REGS_SVH
`define NDEF_HOST_REGS_SVH
// Register offsets of the controller
`define REG_CTRL        4'h0
`define REG_CFG         4'h4
`define REG_LEN         4'h8
`define REG_STAT        4'hC
// Control bits, self clearing
`define CTRL_FMT        0
`define CTRL_BEGIN      1
`define CTRL_COMMIT     2
// Configuration fields
`define CFG_VER_LSB     0
`define CFG_MAXB_LSB    8
`define CFG_RW_BIT      24
`define CFG_T3_BIT      25
`define CFG_ENC_BIT     26
`define CFG_RST         32'h0100_1710
// Tag layout values
`define NDEF_SYS_CODE   16'h12FC
`define NDEF_AIB_BLOCK  5'h00
`define NDEF_FILE_BLOCK 5'h01
`define NDEF_LAST_BLOCK 5'h17
`define NDEF_NBR        8'h0F
`define NDEF_NBW        8'h0B
`define MAXB_SHARED     16'h0017
`define MAXB_T3         16'h001A
`define MAXB_ENC        16'h0018
`define WF_BUSY         8'h0F
`define WF_DONE         8'h00
`define EMPTY_MSG       24'hD00000
`define EMPTY_LEN       24'h000003
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ===== ndef_tag_model.sv
`timescale 1ns/10ps
// Behavioural tag: user blocks 0 to 23 plus the system code
module ndef_tag_model (
    input  wire logic                     aclk,      // Clock
    input  wire logic                     aresetn,   // Sync reset, low
    input  wire ndef_host_pkg::tag_req_t  tag_req,   // Order from host
    input  wire logic                     tag_valid, // Order valid
    input  wire logic [3:0]               delay,     // Wait states per order
    output logic                          tag_ready  // Order taken
);
    logic [127:0] mem [0:23]; // Non-volatile user area
    logic [15:0]  sys_code;   // Programmed system code
    logic [5:0]   ord_q [$];  // Log of taken orders, {kind, block}
    int           bad_blk;    // Writes aimed outside the map
    logic [3:0]   wait_r;     // Wait-state counter
    // Memory is not cleared by reset, so start from a non-zero pattern
    initial begin
        for (int i = 0; i < 24; i++) begin
            mem[i] = {16{8'hA5}};
        end
        sys_code = 16'h0000;
        bad_blk  = 0;
    end
    // Ready drops right after each take, so one order is stored once
    always @(posedge aclk) begin
        if (!aresetn) begin
            tag_ready <= 1'b0;
            wait_r    <= 4'h0;
        end else if (tag_valid && tag_ready) begin
            tag_ready <= 1'b0;
            wait_r    <= 4'h0;
            ord_q.push_back({tag_req.kind, tag_req.block});
            if (tag_req.kind == ndef_host_pkg::req_syscode) begin
                sys_code <= tag_req.data[15:0];
            end else if (tag_req.block > 5'h17) begin
                bad_blk++;
            end else if (tag_req.block != 5'h00 || mem[0][47:40] !== 8'h00) begin
                mem[tag_req.block] <= tag_req.data;
            end
        end else if (tag_valid) begin
            if (wait_r >= delay) tag_ready <= 1'b1;
            else wait_r <= wait_r + 4'h1;
        end
    end
endmodule // ndef_tag_model
